// File: ssp_slave.v
/*
  spi target side of a motion sensor serial port: mode 3, 3- or 4-wire,
  first byte rw/burst/address, auto-increment bursts, register access port.
  assumes link pins are asynchronous and sampled by clk (100 MHz), and that
  the register file outside answers regRdData combinationally from regAddr.
*/
`timescale 1ns/100ps
`include "ssp_defines.vh"

// Notes on behaviour
// - only ever a target; no transfer is started from this side.
// - chip-select high means two-wire mode; low means spi transaction.
// - format bit 6 at 0x31 clear gives 4-wire, set gives 3-wire.
// - clock polarity one, phase one; master stays at or below 5 MHz.
// - outputs change on falling edge, inputs sampled on rising edge.
// - in burst, pointer advances by one every further eight clocks.
// - serial output released within 10 ns after chip-select rises.
// - with chip-select high, two-wire style traffic goes to two-wire logic.
module ssp_slave (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  input  wire       clkEn,
  // spi pins
  input  wire       csN,
  input  wire       sclk,
  input  wire       sdi,
  output reg        sdo,
  output wire       sdoOe,
  input  wire       sdioIn,
  output reg        sdioOut,
  output wire       sdioOe,
  // mode
  output wire       twoWireMode,
  output wire       threeWire,
  // register access
  output reg  [5:0] regAddr,
  output reg  [7:0] regWrData,
  output reg        regWrEn,
  output reg        regRdEn,
  input  wire [7:0] regRdData
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CMD  = 4'b0010;
  localparam [3:0] ST_WR   = 4'b0100;
  localparam [3:0] ST_RD   = 4'b1000;

  wire [3:0] pinSync;
  wire       csS;
  wire       sclkS;
  wire       sdiS;
  wire       sdioS;

  reg  [3:0] state_q;
  reg        sclkPrev_q;
  reg  [2:0] bitCnt_q;
  reg  [7:0] shift_q;
  reg  [7:0] tx_q;
  reg        burst_increment_flag_q;
  reg        firstData_q;
  reg  [7:0] fmt_q;
  reg        drive_q;

  ssp_sync #(
    .WIDTH  (4),
    .RSTVAL (4'b1111)
  ) u_sync (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .din   ({sdioIn, sdi, sclk, csN}),
    .dout  (pinSync)
  );

  assign csS   = pinSync[0];
  assign sclkS = pinSync[1];
  assign sdiS  = pinSync[2];
  assign sdioS = pinSync[3];

  wire rise   = sclkS & ~sclkPrev_q;
  wire fall   = ~sclkS & sclkPrev_q;
  wire inBit  = threeWire ? sdioS : sdiS;

  assign twoWireMode = csS;
  assign threeWire   = fmt_q[`SSP_FMT_WIRE_BIT];

  // raw pin gating so release follows chip-select without sync delay
  assign sdoOe  = drive_q & ~threeWire & ~csN;
  assign sdioOe = drive_q & threeWire & ~csN;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q                <= ST_IDLE;
      sclkPrev_q             <= 1'b1;
      bitCnt_q               <= 3'h0;
      shift_q                <= 8'h00;
      tx_q                   <= 8'h00;
      burst_increment_flag_q <= 1'b0;
      firstData_q            <= 1'b0;
      fmt_q                  <= `SSP_FMT_RESET;
      drive_q                <= 1'b0;
      regAddr                <= 6'h00;
      regWrData              <= 8'h00;
      regWrEn                <= 1'b0;
      regRdEn                <= 1'b0;
      sdo                    <= 1'b0;
      sdioOut                <= 1'b0;
    end else if (clkEn) begin
      sclkPrev_q <= sclkS;
      regWrEn    <= 1'b0;
      regRdEn    <= 1'b0;
      if (csS) begin
        // deselect ends any transfer; two-wire logic owns the lines
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            bitCnt_q <= 3'h0;
            state_q  <= ST_CMD;
          end
          ST_CMD: begin
            if (rise) begin
              shift_q  <= {shift_q[6:0], inBit};
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                burst_increment_flag_q <= shift_q[`SSP_BURST_BIT - 1];
                regAddr     <= {shift_q[4:0], inBit};
                firstData_q <= 1'b1;
                if (shift_q[`SSP_RW_BIT - 1]) begin
                  state_q <= ST_RD;
                  regRdEn <= 1'b1;
                  tx_q    <= 8'h00;
                end else begin
                  state_q <= ST_WR;
                end
              end
            end
          end
          ST_WR: begin
            if (rise) begin
              shift_q  <= {shift_q[6:0], inBit};
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h0 && !firstData_q && burst_increment_flag_q) begin
                regAddr <= regAddr + 6'h01;
              end
              if (bitCnt_q == 3'h7) begin
                firstData_q <= 1'b0;
                regWrData   <= {shift_q[6:0], inBit};
                if (firstData_q || burst_increment_flag_q) begin
                  regWrEn <= 1'b1;
                end
                if (regAddr == `SSP_FMT_ADDR && (firstData_q || burst_increment_flag_q)) begin
                  fmt_q <= {shift_q[6:0], inBit};
                end
              end
            end
          end
          ST_RD: begin
            if (regRdEn) begin
              tx_q <= (regAddr == `SSP_FMT_ADDR) ? fmt_q : regRdData;
            end
            if (fall) begin
              drive_q <= 1'b1;
              sdo     <= tx_q[7];
              sdioOut <= tx_q[7];
              tx_q    <= {tx_q[6:0], 1'b0};
            end
            if (rise) begin
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7 && burst_increment_flag_q) begin
                regAddr <= regAddr + 6'h01;
                regRdEn <= 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// File: ssp_defines.vh
/*
  constants for the sensor serial slave port: first-byte layout, wire-select bit,
  timing figures and derived clock counts. assumes a 100 MHz system clock.
*/
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

`define SSP_CLK_PERIOD_NS   10
`define SSP_RW_BIT          7
`define SSP_BURST_BIT       6
`define SSP_ADDR_MSB        5
`define SSP_ADDR_W          6
`define SSP_FMT_ADDR        6'h31
`define SSP_FMT_WIRE_BIT    6
`define SSP_FMT_RESET       8'h00
`define SSP_DIS_NS          10
`define SSP_DIS_CYC         ((`SSP_DIS_NS / `SSP_CLK_PERIOD_NS) < 1 ? 1 : (`SSP_DIS_NS / `SSP_CLK_PERIOD_NS))
`define SSP_SCLK_MAX_KHZ    5000

`endif

// File: ssp_sync.v
/*
  two-flop synchroniser for a bundle of pin inputs.
  assumes inputs are asynchronous to clk; set value is the idle level.
*/
`timescale 1ns/100ps
module ssp_sync #(
  parameter       WIDTH   = 3,
  parameter [WIDTH-1:0] RSTVAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             clkEn,
  // data
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1Q;
  reg [WIDTH-1:0] stage2Q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1Q[i] <= RSTVAL[i];
          stage2Q[i] <= RSTVAL[i];
        end else if (clkEn) begin
          stage1Q[i] <= din[i];
          stage2Q[i] <= stage1Q[i];
        end
      end
    end
  endgenerate

  assign dout = stage2Q;
endmodule

// File: ssp_slave_assertions.sv
/* checker on the ssp_slave ports, bound below.
   assumes clkEn held high. */
`timescale 1ns/100ps
module ssp_slave_chk (
  // clock, reset, pins and strobes
  input wire clk, rst, csN, sclk, sdo, sdoOe, sdioOe,
  input wire twoWireMode, threeWire, regWrEn, regRdEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sel; !csN [*4]; endsequence
  property p_mode; s_sel |-> !twoWireMode; endproperty
  a_mode: assert property (p_mode) else $error("mode flag in frame");
  property p_idle; csN [*4] |-> !regWrEn && !regRdEn; endproperty
  a_idle: assert property (p_idle) else $error("strobe while idle");
  property p_rel; csN |-> !sdoOe && !sdioOe; endproperty
  a_rel: assert property (p_rel) else $error("output kept");
  property p_4w; sdoOe |-> !threeWire; endproperty
  a_4w: assert property (p_4w) else $error("sdo in 3-wire");
  property p_3w; sdioOe |-> threeWire; endproperty
  a_3w: assert property (p_3w) else $error("sdio in 4-wire");
  property p_wr; regWrEn |=> !regWrEn [*8]; endproperty
  a_wr: assert property (p_wr) else $error("write too close");
  property p_rd; regRdEn |=> !regRdEn [*8]; endproperty
  a_rd: assert property (p_rd) else $error("read too close");
  property p_sdo; $changed(sdo) && sdoOe |-> !sclk; endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved high");
endmodule
bind ssp_slave ssp_slave_chk ssp_slave_chk_inst (.*);

// File: ssp_spi_master.sv
/* master model: mode 3 frames paced from clk.
   assumes a pull-up on the shared line. */
`timescale 1ns/100ps
module ssp_spi_master (
  // clock and link pins
  input wire   clk, sdo, sdoOe, sdioOut, sdioOe,
  output logic csN, sclk,
  output wire  sdi, sdioIn
);
  logic bitQ = 1'b1;
  logic drv = 1'b0;
  initial {csN, sclk} = 2'b11;
  assign sdi = bitQ | csN;
  assign sdioIn = sdioOe ? sdioOut : (drv ? bitQ : 1'b1);
  task automatic hp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic [7:0] tx [$], input logic w3, output logic [7:0] rx [$]);
    logic [7:0] r;
    rx = {};
    csN = 0;
    hp(13);
    for (int i = 0; i < tx.size() * 8; i++) begin
      drv = i < 8 || !tx[0][7];
      sclk = 0;
      bitQ = tx[i / 8][7 - i % 8];
      hp(13);
      sclk = 1;
      r = {r[6:0], w3 ? sdioIn : (sdoOe ? sdo : ~sdo)};
      if (i % 8 == 7) rx.push_back(r);
      hp(13);
    end
    csN = 1;
    hp(26);
  endtask
endmodule

// File: tb.sv
/* bench for ssp_slave with a master model and a register array.
   assumes the checker bind and ssp_spi_master. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin numChecks++; if ((e) !== (s)) begin errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  logic        clk = 0, rst = 1, w3 = 0;
  logic [7:0]  mdl [64], mem [64], rx [$], tx [$];
  logic [13:0] expQ [$], e;
  int          errors, numChecks;
  wire         csN, sclk, sdi, sdo, sdoOe, sdioIn, sdioOut, sdioOe, twoWireMode, threeWire, regWrEn, regRdEn;
  wire  [5:0]  regAddr;
  wire  [7:0]  regWrData;
  ssp_slave ssp_slave_inst (.clkEn(1'b1), .regRdData(mem[regAddr]), .*);
  ssp_spi_master ssp_spi_master_inst (.*);
  initial forever #5 clk = ~clk;
  initial begin
    #400000;
    errors++;
    finalReport();
  end
  task automatic finalReport;
    if (errors == 0 && numChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clk) if (regWrEn === 1'b1) begin
    e = expQ.size() ? expQ.pop_front() : 14'h3fff;
    `CHK("write", e, {regAddr, regWrData})
    mem[regAddr] <= regWrData;
  end
  task automatic go(input logic [5:0] a, input int n, input logic rdB, input logic burst);
    tx = {{rdB, burst, a}};
    repeat (n) tx.push_back(a == 6'h31 ? {1'b0, ~w3, 6'h00} : 8'($urandom));
    for (int i = 0; i < n; i++)
      if (!rdB && (burst || i == 0)) begin
        expQ.push_back({6'(a + i), tx[i + 1]});
        mdl[6'(a + i)] = tx[i + 1];
      end
    ssp_spi_master_inst.frame(tx, w3, rx);
    for (int i = 0; i < n; i++)
      if (rdB) `CHK("read", mdl[6'(a + i)], rx[i + 1])
  endtask
  initial begin
    logic [5:0] a;
    void'($urandom(32'hc84c));
    foreach (mem[i]) begin
      mem[i] = 8'($urandom);
      mdl[i] = mem[i];
    end
    repeat (16) @(posedge clk);
    #1 rst = 0;
    `CHK("idle", 3'b100, {twoWireMode, threeWire, sdoOe})
    #30;
    for (int k = 0; k < 2; k++) begin
      a = 6'($urandom % 32);
      go(a, 1, 0, 0);
      go(a + 6'd3, 2, 0, 0);
      go(a + 6'd6, 3, 0, 1);
      go(a, 1, 1, 0);
      go(a + 6'd6, 3, 1, 1);
      go(6'h31, 1, 0, 0);
      w3 = ~w3;
      `CHK("wires", w3, threeWire)
    end
    `CHK("left", 0, expQ.size())
    finalReport();
  end
endmodule
